// ===== core/preload_observe_defines.svh
// Constants for the power-up clear and test-access block.
// Assumes a 40 MHz core clock; included by the package and the design files.
`ifndef PRELOAD_OBSERVE_DEFINES_SVH
`define PRELOAD_OBSERVE_DEFINES_SVH

// Clock period in ns and clear time in us
`define CLK_PERIOD_NS       25
`define POWER_UP_CLEAR_US   10
// Longest time rounds down: 10000 ns / 25 ns = 400 cycles
`define POWER_UP_CLEAR_CYC  ((`POWER_UP_CLEAR_US * 1000) / `CLK_PERIOD_NS)
`define CLR_CNT_W           9

// Register and pin counts
`define NUM_OUT             8
`define NUM_BURIED          8
`define NUM_REGS            16

// APB register byte addresses
`define ADDR_MODE           12'h000
`define ADDR_POLARITY       12'h004
`define ADDR_COMB_SEL       12'h008
`define ADDR_OE_CFG         12'h00c
`define ADDR_STATUS         12'h010
`define ADDR_REGS           12'h014
`define ADDR_ASYNC_CFG      12'h018
`define ADDR_FUNC_IN        12'h01c
`define ADDR_W              12

// Test mode encodings
`define MODE_NORMAL         2'h0
`define MODE_PRELOAD        2'h1
`define MODE_OBSERVE        2'h2

`endif

// ===== core/preload_observe_pkg.sv
// Types for the power-up clear and test-access block.
// Assumes the defines header is on the include path.
`include "preload_observe_defines.svh"

package preload_observe_pkg;
  // Test mode selection
  typedef logic [1:0] test_mode_t;
  // Power-up clear sequencer states
  typedef enum logic [1:0] {
    ST_CLEAR,
    ST_RUN
  } clr_state_t;
endpackage : preload_observe_pkg

// ===== core/cell_flop.sv
// One device flip-flop with preload, async reset/preset and power-up clear.
// Assumes the parent supplies the mode and async lines per cell.
`timescale 1ns/100ps
`include "preload_observe_defines.svh"

module cell_flop (
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic rst_i,
  // Control
  input  wire logic clear_i,
  input  wire logic preload_i,
  input  wire logic preload_val_i,
  input  wire logic d_i,
  input  wire logic async_rst_i,
  input  wire logic async_set_i,
  // State
  output logic      q_o
);
  // Async lines win over preload in the same cycle, so they can overwrite a preloaded cell
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      q_o <= 1'b0;
    end else if (clear_i) begin
      q_o <= 1'b0;
    end else if (async_rst_i) begin
      q_o <= 1'b0;
    end else if (async_set_i) begin
      q_o <= 1'b1;
    end else if (preload_i) begin
      q_o <= preload_val_i;
    end else begin
      q_o <= d_i;
    end
  end
endmodule : cell_flop

// ===== core/preload_observe.sv
// Power-up clear, preload and observe logic for a set of output and buried
// flip-flops, with an APB register window. Assumes synchronous pins and an
// APB master on the same 40 MHz clock.
//
// Design decisions made here: the placing of the registers and the APB slave port.
`timescale 1ns/100ps
`include "preload_observe_defines.svh"

module preload_observe (
  // Clock and reset
  input  wire logic                            core_clk_i,
  input  wire logic                            rst_i,
  // APB slave
  input  wire logic                            psel_i,
  input  wire logic                            penable_i,
  input  wire logic                            pwrite_i,
  input  wire logic [`ADDR_W-1:0]              paddr_i,
  input  wire logic [31:0]                     pwdata_i,
  output logic      [31:0]                     prdata_o,
  output logic                                 pready_o,
  output logic                                 pslverr_o,
  // Test mode select
  input  wire preload_observe_pkg::test_mode_t test_mode_i,
  // I/O pins, output and buried banks
  input  wire logic [`NUM_REGS-1:0]            pin_i,
  output logic      [`NUM_REGS-1:0]            pin_o,
  output logic      [`NUM_REGS-1:0]            pin_oe_o,
  // Status
  output logic                                 clear_done_o
);
  import preload_observe_pkg::*;

  // ****************************************************************
  // Software-visible configuration
  // ****************************************************************
  logic [`NUM_OUT-1:0]  polarity_reg;   // 1 = invert at pin
  logic [`NUM_OUT-1:0]  comb_sel_reg;   // 1 = output is combinatorial
  logic [`NUM_OUT-1:0]  oe_cfg_reg;     // Programmed output enables
  logic [`NUM_REGS-1:0] async_cfg_reg;  // Cell i drives async reset of cell i+1
  logic [`NUM_REGS-1:0] func_in_reg;    // Functional D inputs / product terms
  logic [`NUM_REGS-1:0] q;
  logic                 apb_wr;
  logic                 apb_rd;
  logic                 addr_ok;

  assign apb_wr  = psel_i && penable_i && pwrite_i;
  assign apb_rd  = psel_i && !pwrite_i;
  assign addr_ok = (paddr_i == `ADDR_MODE)     || (paddr_i == `ADDR_POLARITY)
                || (paddr_i == `ADDR_COMB_SEL) || (paddr_i == `ADDR_OE_CFG)
                || (paddr_i == `ADDR_STATUS)   || (paddr_i == `ADDR_REGS)
                || (paddr_i == `ADDR_ASYNC_CFG) || (paddr_i == `ADDR_FUNC_IN);

  // Zero-wait slave: every access completes in its first access cycle
  // pslverr flags unmapped addresses; reads there return zeros
  assign pready_o  = psel_i && penable_i;
  assign pslverr_o = psel_i && penable_i && !addr_ok;

  // Configuration writes; MODE, STATUS and REGS are read-only views, so a
  // write to them falls to the default branch and changes nothing
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      polarity_reg  <= 8'h00;
      comb_sel_reg  <= 8'h00;
      oe_cfg_reg    <= 8'h00;
      async_cfg_reg <= 16'h0000;
      func_in_reg   <= 16'h0000;
    end else if (apb_wr) begin
      case (paddr_i)
        `ADDR_POLARITY:  polarity_reg  <= pwdata_i[`NUM_OUT-1:0];
        `ADDR_COMB_SEL:  comb_sel_reg  <= pwdata_i[`NUM_OUT-1:0];
        `ADDR_OE_CFG:    oe_cfg_reg    <= pwdata_i[`NUM_OUT-1:0];
        `ADDR_ASYNC_CFG: async_cfg_reg <= pwdata_i[`NUM_REGS-1:0];
        `ADDR_FUNC_IN:   func_in_reg   <= pwdata_i[`NUM_REGS-1:0];
        default: ;
      endcase
    end
  end

  // ****************************************************************
  // Power-up clear sequencer
  // ****************************************************************
  clr_state_t           clr_state_reg;
  logic [`CLR_CNT_W-1:0] clr_cnt_reg;
  logic                 clearing;

  // Clear runs for the full allowed window and no longer, so the host's
  // wait after reset is bounded. The counter width suits clocks up to 51.2 MHz
  // only: a faster clock needs more than 512 cycles and a wider count.
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      clr_state_reg <= ST_CLEAR;
      clr_cnt_reg   <= '0;
    end else begin
      case (clr_state_reg)
        ST_CLEAR: begin
          if (clr_cnt_reg == `CLR_CNT_W'(`POWER_UP_CLEAR_CYC - 1)) begin
            clr_state_reg <= ST_RUN;
          end else begin
            clr_cnt_reg <= clr_cnt_reg + `CLR_CNT_W'(1);
          end
        end
        ST_RUN:  clr_state_reg <= ST_RUN;
        default: clr_state_reg <= ST_CLEAR;
      endcase
    end
  end

  assign clearing     = (clr_state_reg != ST_RUN);
  assign clear_done_o = !clearing;

  // ****************************************************************
  // Test mode decode
  // ****************************************************************
  logic preload_mode;
  logic observe_mode;
  logic test_active;

  // Modes only take effect after the clear, so preload cannot race it
  // Mode 3 is not a test mode and behaves as normal operation
  assign preload_mode = !clearing && (test_mode_i == `MODE_PRELOAD);
  assign observe_mode = !clearing && (test_mode_i == `MODE_OBSERVE);
  assign test_active  = preload_mode || observe_mode;

  // ****************************************************************
  // Flip-flop array
  // ****************************************************************
  logic [`NUM_REGS-1:0] async_rst;
  logic [`NUM_REGS-1:0] d_val;

  // Cell i's stored value may reset cell i+1; a preloaded 1 there clears it
  // The top cell's chain bit has no successor and is ignored
  assign async_rst = {q[`NUM_REGS-2:0] & async_cfg_reg[`NUM_REGS-2:0], 1'b0};

  // Product terms are zeroed for combinatorial cells while a test mode runs
  always_comb begin
    d_val = func_in_reg;
    if (test_active) begin
      d_val[`NUM_OUT-1:0] = func_in_reg[`NUM_OUT-1:0] & ~comb_sel_reg;
    end
  end

  // One cell per flip-flop. Preset lines are not modelled, so every set
  // input is held inactive; only the reset chain shows the preload hazard.
  genvar gi;
  generate
    for (gi = 0; gi < `NUM_REGS; gi = gi + 1) begin : g_cell
      cell_flop u_cell (
        .clk_i         (core_clk_i),
        .rst_i         (rst_i),
        .clear_i       (clearing),
        .preload_i     (preload_mode),
        .preload_val_i (pin_i[gi]),
        .d_i           (d_val[gi]),
        .async_rst_i   (async_rst[gi]),
        .async_set_i   (1'b0),
        .q_o           (q[gi])
      );
    end
  endgenerate

  // ****************************************************************
  // Pin drive
  // ****************************************************************
  logic [`NUM_OUT-1:0] out_val;

  // Combinatorial cells bypass the flop unless a test mode forces registers
  // Polarity applies after the bypass, so both paths are inverted alike
  always_comb begin
    for (int i = 0; i < `NUM_OUT; i++) begin
      if (comb_sel_reg[i] && !test_active) begin
        out_val[i] = func_in_reg[i];
      end else begin
        out_val[i] = q[i];
      end
    end
  end

  // Buried cells reach pins only in observe; preload keeps buffers off
  always_comb begin
    pin_o    = {q[`NUM_REGS-1:`NUM_OUT], out_val ^ polarity_reg};
    pin_oe_o = '0;
    if (observe_mode) begin
      pin_oe_o = '1;
    end else if (!preload_mode) begin
      pin_oe_o[`NUM_OUT-1:0] = oe_cfg_reg;
    end
  end

  // ****************************************************************
  // Read data
  // ****************************************************************
  // Combinational so the answer stands in the zero-wait access phase;
  // outside a read the bus sees zeros rather than a stale register.
  always_comb begin
    prdata_o = 32'h0000_0000;
    if (apb_rd) begin
      case (paddr_i)
        `ADDR_MODE:      prdata_o = {30'h0, test_mode_i};
        `ADDR_POLARITY:  prdata_o = {24'h0, polarity_reg};
        `ADDR_COMB_SEL:  prdata_o = {24'h0, comb_sel_reg};
        `ADDR_OE_CFG:    prdata_o = {24'h0, oe_cfg_reg};
        `ADDR_STATUS:    prdata_o = {29'h0, observe_mode, preload_mode, clear_done_o};
        `ADDR_REGS:      prdata_o = {16'h0, q};
        `ADDR_ASYNC_CFG: prdata_o = {16'h0, async_cfg_reg};
        `ADDR_FUNC_IN:   prdata_o = {16'h0, func_in_reg};
        default:         prdata_o = 32'h0000_0000;
      endcase
    end
  end
endmodule : preload_observe

// ===== verif/preload_observe_chk.sv
// Checker: port-level relations of the test-access block.
// Assumes it is bound to preload_observe and sees its ports only.
`timescale 1ns/100ps
`include "preload_observe_defines.svh"
module preload_observe_chk (
  // Clock, reset and bus
  input wire logic                      core_clk_i,
  input wire logic                      rst_i,
  input wire logic                      psel_i,
  input wire logic                      penable_i,
  input wire logic                      pwrite_i,
  input wire logic [`ADDR_W-1:0]        paddr_i,
  input wire logic [31:0]               prdata_o,
  input wire logic                      pready_o,
  input wire logic                      pslverr_o,
  // Test side
  input wire preload_observe_pkg::test_mode_t test_mode_i,
  input wire logic [15:0]               pin_i,
  input wire logic [15:0]               pin_o,
  input wire logic [15:0]               pin_oe_o,
  input wire logic                      clear_done_o
);
  import preload_observe_pkg::*;
  logic [8:0] wait_reg;
  // Edges spent clearing; an exact figure catches an early finish as well as a late one
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) wait_reg <= 9'h0;
    else if (!clear_done_o) wait_reg <= wait_reg + 9'h1;
  end
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  clear_time_a: assert property (clear_done_o == (wait_reg == 9'h190)) else $error("clear time wrong");
  err_resp_a: assert property (psel_i && penable_i && paddr_i > `ADDR_FUNC_IN |-> pslverr_o && prdata_o == 32'h0)
    else $error("unmapped access not refused");
  zero_wait_a: assert property (pready_o == (psel_i && penable_i)) else $error("access not answered at once");
  idle_rd_a: assert property (!psel_i || pwrite_i |-> prdata_o == 32'h0) else $error("idle read data");
  mode_rd_a: assert property (psel_i && !pwrite_i && paddr_i == `ADDR_MODE |-> prdata_o == {30'h0, test_mode_i})
    else $error("mode readback");
  status_rd_a: assert property (psel_i && !pwrite_i && paddr_i == `ADDR_STATUS |-> prdata_o[0] == clear_done_o)
    else $error("status readback");
  observe_oe_a: assert property (clear_done_o && test_mode_i == `MODE_OBSERVE |-> pin_oe_o == 16'hffff)
    else $error("observe enables");
  preload_oe_a: assert property (clear_done_o && test_mode_i == `MODE_PRELOAD |-> pin_oe_o == 16'h0)
    else $error("preload enables");
  buried_oe_a: assert property (!clear_done_o || test_mode_i[0] == test_mode_i[1] |-> pin_oe_o[15:8] == 8'h0)
    else $error("buried bank driven");
  preload_ld_a: assert property (clear_done_o && test_mode_i == `MODE_PRELOAD ##1 test_mode_i == `MODE_OBSERVE
    |-> pin_o[15:8] == $past(pin_i[15:8])) else $error("preload not shown");
endmodule : preload_observe_chk

bind preload_observe preload_observe_chk preload_observe_chk_inst (.core_clk_i(core_clk_i), .rst_i(rst_i),
  .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .prdata_o(prdata_o),
  .pready_o(pready_o), .pslverr_o(pslverr_o), .test_mode_i(test_mode_i), .pin_i(pin_i), .pin_o(pin_o),
  .pin_oe_o(pin_oe_o),
  .clear_done_o(clear_done_o));

// ===== verif/pin_tester.sv
// Tester model: drives the mode select and the pins.
// Assumes the bench asks for each change one edge ahead.
`timescale 1ns/100ps
`include "preload_observe_defines.svh"
module pin_tester (
  // Clock, reset and requests
  input  wire logic                            clk_i,
  input  wire logic                            rst_i,
  input  wire preload_observe_pkg::test_mode_t mode_req_i,
  input  wire logic [15:0]                     pat_i,
  // Pin side
  output preload_observe_pkg::test_mode_t      mode_o,
  output logic [15:0]                          pins_o
);
  import preload_observe_pkg::*;
  // Pattern only in preload; elsewhere the pins wander so a stale value cannot pass
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      mode_o <= `MODE_NORMAL;
      pins_o <= 16'h0;
    end else begin
      mode_o <= mode_req_i;
      pins_o <= (mode_req_i == `MODE_PRELOAD) ? pat_i : ~pins_o;
    end
  end
endmodule : pin_tester

// ===== verif/test_preload_observe.sv
// Bench: clear timing, preload, observe and register window.
// Assumes the block, its checker and the tester model are compiled first.
`timescale 1ns/100ps
`include "preload_observe_defines.svh"
module test_preload_observe;
  import preload_observe_pkg::*;
  logic core_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic psel, pen, pwr, pready, err, pslverr, done;
  logic [`ADDR_W-1:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  test_mode_t mode_req, mode;
  logic [15:0] pat, pins, pin_o, pin_oe;
  int mismatches = 0;
  int tests_run = 0;
  int n;

  always #12.5 core_clk_i = ~core_clk_i;

  preload_observe preload_observe_inst (.core_clk_i(core_clk_i), .rst_i(rst_i), .psel_i(psel), .penable_i(pen),
    .pwrite_i(pwr), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
    .pslverr_o(pslverr), .test_mode_i(mode), .pin_i(pins), .pin_o(pin_o), .pin_oe_o(pin_oe), .clear_done_o(done));
  pin_tester pin_tester_inst (.clk_i(core_clk_i), .rst_i(rst_i), .mode_req_i(mode_req), .pat_i(pat),
    .mode_o(mode), .pins_o(pins));

  task check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task print_verdict;
    $display("Comparisons %0d, mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : print_verdict

  // One APB transfer; request held until pready is seen at an edge
  task apb(input logic w, input logic [`ADDR_W-1:0] a, input logic [31:0] d);
    @(posedge core_clk_i);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk_i);
    pen <= 1'b1;
    do @(posedge core_clk_i); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask : apb

  // Mode reaches the block through the tester one edge later
  task mode_to(input test_mode_t m, input logic [15:0] p);
    @(posedge core_clk_i);
    mode_req <= m;
    pat <= p;
    @(posedge core_clk_i);
    #1;
  endtask : mode_to

  // Release reset and count edges until the clear is reported
  task wait_clear;
    rst_i <= 1'b0;
    n = 0;
    while (done !== 1'b1 && n < 1000) begin
      @(posedge core_clk_i);
      #1;
      n++;
    end
  endtask : wait_clear

  initial begin
    {psel, pen, pwr, paddr, pwdata, pat} = '0;
    mode_req = `MODE_NORMAL;
    repeat (3) @(posedge core_clk_i);
    check(pin_oe, 32'h0);
    wait_clear();
    check(n, 32'd400);
    apb(0, `ADDR_REGS, 0);
    check(rd, 32'h0);
    apb(1, `ADDR_POLARITY, 32'ha5);
    apb(1, `ADDR_OE_CFG, 32'hff);
    #1;
    check({pin_oe, pin_o}, 32'h00ff_00a5);
    apb(0, `ADDR_STATUS, 0);
    check(rd, 32'h1);
    apb(0, 12'h020, 0);
    check(err, 1'b1);
    // Preload a pattern, then look at it in the first observe cycle
    mode_to(`MODE_PRELOAD, 16'h5a3c);
    apb(0, `ADDR_MODE, 0);
    check(rd, 32'h1);
    apb(0, `ADDR_STATUS, 0);
    check(rd, 32'h3);
    apb(0, `ADDR_REGS, 0);
    check(rd, 32'h5a3c);
    mode_to(`MODE_OBSERVE, 16'h0);
    check({pin_oe, pin_o}, 32'hffff_5a99);
    // Only flop 0 resets flop 1, so no other preload state trips a reset
    mode_to(`MODE_NORMAL, 16'h0);
    apb(1, `ADDR_ASYNC_CFG, 32'h1);
    mode_to(`MODE_PRELOAD, 16'h0003);
    apb(0, `ADDR_REGS, 0);
    check(rd, 32'h1);
    mode_to(`MODE_NORMAL, 16'h0);
    apb(1, `ADDR_ASYNC_CFG, 32'h0);
    // Output 0 combinatorial: forced registered with zero terms in observe
    apb(1, `ADDR_COMB_SEL, 32'h1);
    apb(1, `ADDR_FUNC_IN, 32'h1);
    #1;
    check(pin_o[7:0], 8'ha4);
    mode_to(`MODE_OBSERVE, 16'h0);
    @(posedge core_clk_i);
    #1;
    check(pin_o[7:0], 8'ha5);
    mode_to(`MODE_NORMAL, 16'h0);
    check(pin_o[7:0], 8'ha4);
    // Mode 3 is no test mode: enables stay programmed and nothing is preloaded
    mode_to(2'h3, 16'h00f0);
    check(pin_oe, 32'h00ff);
    check(pin_o[7:0], 8'ha4);
    apb(0, `ADDR_STATUS, 0);
    check(rd, 32'h1);
    apb(0, `ADDR_REGS, 0);
    check(rd, 32'h1);
    // Second reset in mid-run
    @(posedge core_clk_i);
    rst_i <= 1'b1;
    @(posedge core_clk_i);
    #1;
    check({done, pin_oe}, 32'h0);
    wait_clear();
    check(n, 32'd400);
    print_verdict();
  end

  // Watchdog: the run needs about 870 cycles
  initial begin
    repeat (3000) @(posedge core_clk_i);
    mismatches++;
    print_verdict();
  end
endmodule : test_preload_observe
